// file: rtl/rtc_consts.vh
// constants for the rtc control and status block
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH
// register offsets
`define OFF_RATE_OSC        8'h0a
`define OFF_INT_FMT         8'h0b
`define OFF_EVENT_STATUS    8'h0c
`define OFF_ALARM_DAY       8'h0d
// rate_oscillator_control fields
`define BIT_UPDATE_IN_PROG  7
`define OSC_MSB             6
`define OSC_LSB             4
`define OSC_RUN_A           3'h2
`define OSC_RUN_B           3'h3
`define OSC_HOLD_MASK       3'h6
`define RATE_MSB            3
// interrupt_format_control fields
`define BIT_TRANSFER_INHIB  7
`define BIT_PERIODIC_IE     6
`define BIT_ALARM_IE        5
`define BIT_UPDATE_IE       4
`define BIT_NUMBER_FMT      2
`define BIT_HOUR_FMT        1
`define BIT_DST_EN          0
// event_status fields
`define BIT_IRQ_FLAG        7
`define BIT_PERIODIC_FLAG   6
`define BIT_ALARM_FLAG      5
`define BIT_UPDATE_FLAG     4
// reset value of the enable bits of interrupt_format_control
`define INT_FMT_EN_RESET    3'h0
// timing: 32.768 kHz tick from a 200 MHz clock
`define MCLK_HZ             200000000
`define XTAL_HZ             32768
`define XTAL_DIV            (`MCLK_HZ / `XTAL_HZ)
`define TICKS_PER_SEC       32768
`define FIRST_UPDATE_MS     500
`define FIRST_UPDATE_TICKS  (`TICKS_PER_SEC * `FIRST_UPDATE_MS / 1000)
`define BUC_US              244
`define BUC_TICKS           ((`BUC_US * `XTAL_HZ + 999999) / 1000000)
`define UPDATE_US           1984
`define UPDATE_TICKS        ((`UPDATE_US * `XTAL_HZ + 999999) / 1000000)
`define RECOVERY_MS         200
`define RECOVERY_CYCLES     (`RECOVERY_MS * 200000)
`endif

// file: rtl/rtc_tick_divider.v
// crystal-rate tick divider with periodic rate tap
`timescale 1ns/1ps
module rtc_tick_divider #(
    parameter DIV = 6103
) (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       run,
    input  wire [3:0] rate_sel,
    output reg        tick,
    output reg        periodic_pulse
);
    reg  [12:0] pre;
    reg  [14:0] chain;
    wire [14:0] next_chain;
    reg  [3:0]  tap;
    wire        last_pre;

    assign last_pre   = (pre == DIV[12:0] - 13'h0001);
    assign next_chain = chain + 15'h0001;

    // rates 1,2 reuse taps of 8,9; zero gives no event
    always @*
    begin
        case (rate_sel)
            4'h1:    tap = 4'h6;
            4'h2:    tap = 4'h7;
            default: tap = rate_sel - 4'h2;
        endcase
    end

    always @(posedge mclk)
    begin
        if (!rst_n || !run)
        begin
            pre            <= 13'h0000;
            chain          <= 15'h0000;
            tick           <= 1'b0;
            periodic_pulse <= 1'b0;
        end
        else
        begin
            tick           <= last_pre;
            periodic_pulse <= 1'b0;
            if (last_pre)
            begin
                pre   <= 13'h0000;
                chain <= next_chain;
                if (rate_sel != 4'h0 && next_chain[tap] && !chain[tap])
                    periodic_pulse <= 1'b1;
            end
            else
                pre <= pre + 13'h0001;
        end
    end
endmodule // rtc_tick_divider

// file: rtl/rtc_update_control_status.v
// control and status registers of the real-time clock
`timescale 1ns/1ps
`include "rtc_consts.vh"
module rtc_update_control_status #(
    parameter RECOVERY_CYCLES = `RECOVERY_CYCLES,
    parameter TICK_DIV        = `XTAL_DIV
) (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       reg_sel,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       extended_ram_select,
    input  wire       power_fail,
    input  wire       backup_valid,
    input  wire       alarm_match,
    output reg  [7:0] reg_rdata,
    output reg        irq_n_oe,
    output reg        update_in_progress,
    output reg        copy_enable,
    output reg        clock_advance,
    output reg        write_protect,
    output reg        number_format,
    output reg        hour_format_select,
    output reg        daylight_saving_enable
);
    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    reg [2:0] sync_a;
    reg [2:0] sync_b;
    wire pf_s    = sync_b[0];
    wire bv_s    = sync_b[1];
    wire alarm_s = sync_b[2];

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end
        else
        begin
            sync_a <= {alarm_match, backup_valid, power_fail};
            sync_b <= sync_a;
        end
    end

    //------------------------------------------------------------
    // register storage
    //------------------------------------------------------------
    reg [2:0] osc_divider_control;
    reg [3:0] periodic_rate_select;
    reg       transfer_inhibit;
    reg       periodic_irq_enable;
    reg       alarm_irq_enable;
    reg       update_irq_enable;
    reg [5:0] alarm_day_field;
    reg       update_done_flag;
    reg       alarm_flag;
    reg       periodic_flag;
    reg       irq_request_flag;
    reg [31:0] recover_cnt;

    wire host_ok  = reg_sel && !extended_ram_select;
    wire wr_ok    = host_ok && reg_wr && !write_protect;
    wire rd_stat  = host_ok && reg_rd && reg_addr == `OFF_EVENT_STATUS;
    wire div_run  = (osc_divider_control == `OSC_RUN_A) ||
                    (osc_divider_control == `OSC_RUN_B);
    wire osc_hold = (osc_divider_control & `OSC_HOLD_MASK) == `OSC_HOLD_MASK;
    wire osc_on   = div_run || osc_hold;

    //------------------------------------------------------------
    // divider
    //------------------------------------------------------------
    wire tick;
    wire periodic_pulse;

    rtc_tick_divider #(
        .DIV            (TICK_DIV)
    ) u_div (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .run            (div_run),
        .rate_sel       (periodic_rate_select),
        .tick           (tick),
        .periodic_pulse (periodic_pulse)
    );

    //------------------------------------------------------------
    // update sequencer
    //------------------------------------------------------------
    localparam ST_IDLE  = 3'b001;
    localparam ST_PRE   = 3'b010;
    localparam ST_UPD   = 3'b100;
    reg [2:0]  state;
    reg [14:0] sec_cnt;
    reg        first_pending;
    reg        update_end;

    localparam integer FIRST_LAST  = `FIRST_UPDATE_TICKS - 1;
    localparam integer SECOND_LAST = `TICKS_PER_SEC - 1;
    localparam integer PRE_LEAD    = `BUC_TICKS;
    localparam integer UPD_LAST    = `UPDATE_TICKS;

    wire [14:0] sec_last  = first_pending ? FIRST_LAST[14:0] : SECOND_LAST[14:0];
    wire [14:0] pre_start = sec_last - PRE_LEAD[14:0];

    always @(posedge mclk)
    begin
        if (!rst_n || !div_run)
        begin
            state         <= ST_IDLE;
            sec_cnt       <= 15'h0000;
            first_pending <= 1'b1;
            update_end    <= 1'b0;
            clock_advance <= 1'b0;
        end
        else
        begin
            update_end    <= 1'b0;
            clock_advance <= 1'b0;
            if (tick)
            begin
                if (sec_cnt == sec_last)
                    sec_cnt <= 15'h0000;
                else
                    sec_cnt <= sec_cnt + 15'h0001;
                case (state)
                    ST_IDLE:
                    begin
                        // enter pre-update before-update interval ahead of the second
                        if (sec_cnt == pre_start)
                            state <= ST_PRE;
                    end
                    ST_PRE:
                    begin
                        if (sec_cnt == sec_last)
                        begin
                            state         <= ST_UPD;
                            clock_advance <= 1'b1;
                        end
                    end
                    ST_UPD:
                    begin
                        if (sec_cnt == UPD_LAST[14:0])
                        begin
                            state         <= ST_IDLE;
                            update_end    <= 1'b1;
                            first_pending <= 1'b0;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    //------------------------------------------------------------
    // registers and flags
    //------------------------------------------------------------
    wire next_uf = update_end | (update_done_flag & ~rd_stat);
    wire next_af = (update_end & alarm_s) | (alarm_flag & ~rd_stat);
    wire next_pf = periodic_pulse | (periodic_flag & ~rd_stat);
    wire next_ie_u = update_irq_enable & ~transfer_inhibit;
    wire next_irq = (next_uf & next_ie_u & ~transfer_inhibit) |
                    (next_af & alarm_irq_enable) |
                    (next_pf & periodic_irq_enable);
    reg  [7:0] next_rdata;

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            osc_divider_control  <= 3'h0;
            periodic_rate_select <= 4'h0;
            transfer_inhibit     <= 1'b0;
            {periodic_irq_enable, alarm_irq_enable, update_irq_enable} <= `INT_FMT_EN_RESET;
            number_format        <= 1'b0;
            hour_format_select   <= 1'b0;
            daylight_saving_enable <= 1'b0;
            alarm_day_field      <= 6'h00;
            update_done_flag     <= 1'b0;
            alarm_flag           <= 1'b0;
            periodic_flag        <= 1'b0;
            irq_request_flag     <= 1'b0;
            irq_n_oe             <= 1'b0;
            update_in_progress   <= 1'b0;
            copy_enable          <= 1'b0;
            write_protect        <= 1'b1;
            recover_cnt          <= 32'h0;
            reg_rdata            <= 8'h00;
        end
        else
        begin
            // set wins over the clearing read
            update_done_flag <= next_uf;
            alarm_flag       <= next_af;
            periodic_flag    <= next_pf;
            irq_request_flag <= next_irq | (irq_request_flag & ~rd_stat);
            irq_n_oe         <= next_irq | (irq_request_flag & ~rd_stat);
            update_in_progress <= (state != ST_IDLE) && !transfer_inhibit;
            copy_enable      <= !transfer_inhibit;
            if (pf_s)
            begin
                write_protect <= 1'b1;
                recover_cnt   <= 32'h0;
            end
            else if (recover_cnt == RECOVERY_CYCLES - 1)
                write_protect <= 1'b0;
            else
                recover_cnt <= recover_cnt + 32'h1;
            if (transfer_inhibit)
                update_irq_enable <= 1'b0;
            if (wr_ok)
            begin
                case (reg_addr)
                    `OFF_RATE_OSC:
                    begin
                        osc_divider_control  <= reg_wdata[`OSC_MSB:`OSC_LSB];
                        periodic_rate_select <= reg_wdata[`RATE_MSB:0];
                    end
                    `OFF_INT_FMT:
                    begin
                        transfer_inhibit    <= reg_wdata[`BIT_TRANSFER_INHIB];
                        periodic_irq_enable <= reg_wdata[`BIT_PERIODIC_IE];
                        alarm_irq_enable    <= reg_wdata[`BIT_ALARM_IE];
                        update_irq_enable   <= reg_wdata[`BIT_UPDATE_IE] &
                                               ~reg_wdata[`BIT_TRANSFER_INHIB];
                        number_format       <= reg_wdata[`BIT_NUMBER_FMT];
                        hour_format_select  <= reg_wdata[`BIT_HOUR_FMT];
                        daylight_saving_enable <= reg_wdata[`BIT_DST_EN];
                    end
                    `OFF_ALARM_DAY: alarm_day_field <= reg_wdata[5:0];
                    default: ;
                endcase
            end
            if (host_ok && reg_rd)
                reg_rdata <= next_rdata;
        end
    end

    //------------------------------------------------------------
    // read mux
    //------------------------------------------------------------
    always @*
    begin
        case (reg_addr)
            `OFF_RATE_OSC:
                next_rdata = {update_in_progress, osc_divider_control, periodic_rate_select};
            `OFF_INT_FMT:
                next_rdata = {transfer_inhibit, periodic_irq_enable, alarm_irq_enable,
                              update_irq_enable, 1'b0, number_format,
                              hour_format_select, daylight_saving_enable};
            `OFF_EVENT_STATUS:
                next_rdata = {irq_request_flag, periodic_flag, alarm_flag,
                              update_done_flag, 4'h0};
            `OFF_ALARM_DAY:
                next_rdata = {bv_s, 1'b0, alarm_day_field};
            default: next_rdata = 8'h00;
        endcase
    end

    wire unused_osc = osc_on;
endmodule // rtc_update_control_status

// file: tb/host_bus_model.sv
// host processor model driving the register bus
`timescale 1ns/1ps
module host_bus_model (
    input  wire       mclk,
    input  wire [7:0] reg_rdata,
    output reg        reg_sel,
    output reg        reg_wr,
    output reg        reg_rd,
    output reg  [7:0] reg_addr,
    output reg  [7:0] reg_wdata,
    output reg        extended_ram_select
);
    initial
    begin
        reg_sel = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        extended_ram_select = 1'b0;
    end
    // released address and data lines show the inverse so stale values never look valid
    task idle;
        begin
            reg_sel = 1'b0;
            reg_wr = 1'b0;
            reg_rd = 1'b0;
            extended_ram_select = 1'b0;
            reg_addr = ~reg_addr;
            reg_wdata = ~reg_wdata;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d, input x);
        begin
            @(negedge mclk);
            extended_ram_select = x;
            reg_sel = 1'b1;
            reg_wr = 1'b1;
            reg_addr = a;
            reg_wdata = d;
            @(negedge mclk);
            idle;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge mclk);
            reg_sel = 1'b1;
            reg_rd = 1'b1;
            reg_addr = a;
            @(negedge mclk);
            idle;
            d = reg_rdata;
        end
    endtask
endmodule // host_bus_model

// file: tb/rtc_checker_properties.sv
// port-level assertions for the rtc control and status block
`timescale 1ns/1ps
module rtc_checker #(
    parameter RECOVERY_CYCLES = 8
) (
    input wire       mclk,
    input wire       rst_n,
    input wire       reg_sel,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       extended_ram_select,
    input wire       power_fail,
    input wire [7:0] reg_rdata,
    input wire       update_in_progress,
    input wire       copy_enable,
    input wire       clock_advance,
    input wire       write_protect,
    input wire       number_format,
    input wire       hour_format_select,
    input wire       daylight_saving_enable
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    reg  [7:0] wd_q;
    wire       wr_ok = reg_sel && reg_wr && !extended_ram_select && !write_protect;
    wire       rd_ok = reg_sel && reg_rd && !extended_ram_select;
    always @(posedge mclk) wd_q <= reg_wdata;
    property p_wp_reset; $rose(rst_n) |-> write_protect; endproperty
    a_wp_reset: assert property (p_wp_reset) else $error("write protect low at reset exit");
    property p_wp_fail; power_fail [*4] |=> write_protect; endproperty
    a_wp_fail: assert property (p_wp_fail) else $error("writes open in power fail");
    property p_wp_hold; $fell(power_fail) |-> write_protect [*8]; endproperty
    a_wp_hold: assert property (p_wp_hold) else $error("recovery hold too short");
    property p_uip_inhibit; !copy_enable && !$past(copy_enable) |-> !update_in_progress; endproperty
    a_uip_inhibit: assert property (p_uip_inhibit) else $error("update flag set while inhibited");
    property p_copy;
        wr_ok && reg_addr == 8'h0b |-> ##2 copy_enable == !$past(reg_wdata[7], 2);
    endproperty
    a_copy: assert property (p_copy) else $error("copy enable not following inhibit");
    property p_fmt;
        wr_ok && reg_addr == 8'h0b
        |=> {number_format, hour_format_select, daylight_saving_enable} == wd_q[2:0];
    endproperty
    a_fmt: assert property (p_fmt) else $error("format outputs wrong");
    property p_adv_uip; clock_advance && copy_enable |-> update_in_progress; endproperty
    a_adv_uip: assert property (p_adv_uip) else $error("advance without update flag");
    property p_adv_gap; clock_advance |=> !clock_advance [*8]; endproperty
    a_adv_gap: assert property (p_adv_gap) else $error("advance repeated too soon");
    property p_unmapped; rd_ok && reg_addr > 8'h0d |=> reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rdata_hold; !rd_ok ##1 !rd_ok |-> $stable(reg_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    c_fmt_wr: cover property (wr_ok && reg_addr == 8'h0b);
    c_pf_end: cover property ($fell(power_fail));
    c_stat_rd: cover property (rd_ok && reg_addr == 8'h0c);
endmodule // rtc_checker
bind rtc_update_control_status rtc_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_rtc_checker (
    .mclk(mclk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .extended_ram_select(extended_ram_select),
    .power_fail(power_fail), .reg_rdata(reg_rdata), .update_in_progress(update_in_progress),
    .copy_enable(copy_enable), .clock_advance(clock_advance), .write_protect(write_protect),
    .number_format(number_format), .hour_format_select(hour_format_select),
    .daylight_saving_enable(daylight_saving_enable));

// file: tb/tb_rtc_update_control_status.sv
// self-checking bench for the rtc control and status block
`timescale 1ns/1ps
`include "rtc_consts.vh"
module tb_rtc_update_control_status;
    reg        mclk = 1'b0;
    reg        rst_n = 1'b0;
    reg        power_fail = 1'b0;
    reg        backup_valid = 1'b1;
    reg        alarm_match = 1'b0;
    wire       reg_sel, reg_wr, reg_rd, extended_ram_select, irq_n_oe, update_in_progress;
    wire       copy_enable, clock_advance, write_protect, number_format;
    wire       hour_format_select, daylight_saving_enable;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    integer    miscompares = 0;
    integer    cmp_count = 0;
    integer    cycles = 0;
    reg  [7:0] d;
    always #2.5 mclk = ~mclk;
    rtc_update_control_status #(.RECOVERY_CYCLES(8), .TICK_DIV(1)) u_rtc_update_control_status (
        .mclk(mclk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .extended_ram_select(extended_ram_select),
        .power_fail(power_fail), .backup_valid(backup_valid), .alarm_match(alarm_match),
        .reg_rdata(reg_rdata), .irq_n_oe(irq_n_oe), .update_in_progress(update_in_progress),
        .copy_enable(copy_enable), .clock_advance(clock_advance),
        .write_protect(write_protect), .number_format(number_format),
        .hour_format_select(hour_format_select),
        .daylight_saving_enable(daylight_saving_enable));
    host_bus_model u_host_bus_model (
        .mclk(mclk), .reg_rdata(reg_rdata), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .extended_ram_select(extended_ram_select));
    task summarize;
        begin
            if (miscompares == 0 && cmp_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            miscompares = miscompares + 1;
            summarize;
        end
    end
    task check(input [7:0] seen, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp)
            begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wait_unprot;
        integer i;
        begin
            for (i = 0; i < 40 && write_protect !== 1'b0; i = i + 1)
                @(negedge mclk);
            check(write_protect, 8'h00);
        end
    endtask
    task t_reset;
        begin
            check(write_protect, 8'h01);
            check(update_in_progress, 8'h00);
            check(irq_n_oe, 8'h00);
            repeat (4) @(negedge mclk);
            check(write_protect, 8'h01);
            wait_unprot;
            u_host_bus_model.rd(8'h0c, d);
            check(d, 8'h00);
            u_host_bus_model.rd(8'h0b, d);
            check(d & 8'h70, 8'h00);
        end
    endtask
    task t_inhibit;
        begin
            u_host_bus_model.wr(8'h0b, 8'h97, 1'b0);
            u_host_bus_model.rd(8'h0b, d);
            check(d, 8'h87);
            check(copy_enable, 8'h00);
            check(update_in_progress, 8'h00);
            check({number_format, hour_format_select, daylight_saving_enable}, 8'h07);
            u_host_bus_model.wr(8'h0b, 8'h70, 1'b0);
            u_host_bus_model.rd(8'h0b, d);
            check(d, 8'h70);
            check(copy_enable, 8'h01);
            check({number_format, hour_format_select, daylight_saving_enable}, 8'h00);
        end
    endtask
    task t_regs;
        begin
            u_host_bus_model.wr(8'h0a, 8'hff, 1'b0);
            u_host_bus_model.rd(8'h0a, d);
            check(d, 8'h7f);
            u_host_bus_model.wr(8'h0a, 8'h30, 1'b0);
            u_host_bus_model.rd(8'h0a, d);
            check(d, 8'h30);
            u_host_bus_model.wr(8'h0a, 8'h20, 1'b0);
            u_host_bus_model.rd(8'h0a, d);
            check(d, 8'h20);
            check(update_in_progress, 8'h00);
            u_host_bus_model.wr(8'h0d, 8'hff, 1'b0);
            u_host_bus_model.rd(8'h0d, d);
            check(d, 8'hbf);
            @(negedge mclk);
            backup_valid = 1'b0;
            repeat (3) @(negedge mclk);
            u_host_bus_model.rd(8'h0d, d);
            check(d, 8'h3f);
            u_host_bus_model.wr(8'h0c, 8'hff, 1'b0);
            u_host_bus_model.rd(8'h0c, d);
            check(d, 8'h00);
            u_host_bus_model.rd(8'h0e, d);
            check(d, 8'h00);
            u_host_bus_model.wr(8'h0d, 8'h01, 1'b1);
            u_host_bus_model.rd(8'h0d, d);
            check(d, 8'h3f);
        end
    endtask
    task t_power_fail;
        begin
            u_host_bus_model.wr(8'h0b, 8'h02, 1'b0);
            @(negedge mclk);
            power_fail = 1'b1;
            repeat (5) @(negedge mclk);
            check(write_protect, 8'h01);
            u_host_bus_model.wr(8'h0b, 8'h04, 1'b0);
            u_host_bus_model.rd(8'h0b, d);
            check(d, 8'h02);
            power_fail = 1'b0;
            repeat (6) @(negedge mclk);
            check(write_protect, 8'h01);
            wait_unprot;
            u_host_bus_model.wr(8'h0b, 8'h04, 1'b0);
            u_host_bus_model.rd(8'h0b, d);
            check(d, 8'h04);
        end
    endtask
    task t_update;
        integer i;
        begin
            u_host_bus_model.wr(8'h0b, 8'h10, 1'b0);
            for (i = 0; i < 20000 && update_in_progress !== 1'b1; i = i + 1)
                @(negedge mclk);
            check(clock_advance, 8'h00);
            for (i = 0; i < 40 && clock_advance !== 1'b1; i = i + 1)
                @(negedge mclk);
            check(i[7:0], 8'(`BUC_TICKS - 1));
            @(negedge mclk);
            check(clock_advance, 8'h00);
            for (i = 0; i < 200 && irq_n_oe !== 1'b1; i = i + 1)
                @(negedge mclk);
            check(i[7:0], 8'(`UPDATE_TICKS + 1));
            check(update_in_progress, 8'h00);
            check(irq_n_oe, 8'h01);
            u_host_bus_model.rd(8'h0c, d);
            check(d, 8'h90);
            check(irq_n_oe, 8'h00);
            u_host_bus_model.rd(8'h0c, d);
            check(d, 8'h00);
        end
    endtask
    initial
    begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        t_reset;
        t_inhibit;
        t_regs;
        t_power_fail;
        t_update;
        summarize;
    end
endmodule // tb_rtc_update_control_status
